// ==== rtl/sacc_cfg.svh ====
// Constants for the simultaneous converter control block.
// Assumes a 20 MHz system clock; included by package and modules.
`ifndef SACC_CFG_SVH
`define SACC_CFG_SVH
`define SACC_CLK_HZ          20000000
`define SACC_CLK_NS          50
`define SACC_CONV_TIME_NS    4000
`define SACC_CONV_CYC        ((`SACC_CONV_TIME_NS) / (`SACC_CLK_NS))
`define SACC_RANGE_SETTLE_US 80
`define SACC_SETTLE_CYC      ((`SACC_RANGE_SETTLE_US * 1000) / (`SACC_CLK_NS))
`define SACC_ACQ_CYC         20
`define SACC_RESET_CYC       4
`define SACC_CODE_STEPS      16384
`define SACC_NCHAN           8
`define SACC_DW              14
// Avalon register offsets (byte addresses)
`define SACC_REG_CTRL        4'h0
`define SACC_REG_STATUS      4'h4
`define SACC_REG_IRQ_STAT    4'h8
`define SACC_REG_IRQ_CLR     4'hc
`define SACC_REG_IRQ_EN      4'h1
// Control fields
`define SACC_CTRL_START      0
`define SACC_CTRL_SPLIT      1
`define SACC_CTRL_RANGE      2
`define SACC_CTRL_REFSEL     3
`define SACC_CTRL_RESET      4
// Interrupt bits
`define SACC_IRQ_DONE        0
`define SACC_IRQ_REFUSED     1
`define SACC_CTRL_RST_VAL    5'h04
`endif

// ==== rtl/sacc_pkg.sv ====
// Types shared by the converter control ends.
// Assumes sacc_cfg.svh constants.
`include "sacc_cfg.svh"
package sacc_pkg;
    typedef logic signed [`SACC_DW-1:0] sacc_code_t;
    typedef enum logic [1:0] {SACC_D_IDLE, SACC_D_WAIT, SACC_D_CONV}
        sacc_dev_e;
    typedef enum logic [2:0] {SACC_H_RESET, SACC_H_SETTLE, SACC_H_READY,
        SACC_H_WAIT_BUSY, SACC_H_WAIT_DONE} sacc_host_e;
endpackage : sacc_pkg

// ==== rtl/sacc_link_if.sv ====
// Conversion control pins between host and converter.
// Assumes one clock; the testbench connects both modports.
`timescale 1ns/10ps
`include "sacc_cfg.svh"
interface sacc_link_if;
    logic                    start_strobe_first_group;
    logic                    start_strobe_second_group;
    logic                    range_sel;
    logic                    ref_sel;
    logic                    dev_reset;
    logic                    busy;
    logic [`SACC_DW*`SACC_NCHAN-1:0] result;
    modport dev  (input start_strobe_first_group, start_strobe_second_group,
                  range_sel, ref_sel, dev_reset, output busy, result);
    modport host (output start_strobe_first_group,
                  start_strobe_second_group, range_sel, ref_sel, dev_reset,
                  input busy, result);
endinterface : sacc_link_if

// ==== rtl/sacc_coder.sv ====
// Ideal quantiser: two's-complement code of one sample.
// Assumes sample in microvolts, span set by range level.
`timescale 1ns/10ps
`include "sacc_cfg.svh"
module sacc_coder
    import sacc_pkg::*;
(
    // Sample in
    input  wire logic signed [24:0] sample_uv,
    input  wire logic               wide_range,
    // Code out
    output sacc_code_t              code
);
    logic signed [25:0] span_uv;
    logic signed [47:0] scaled;
    logic signed [47:0] q;
    always_comb begin
        // Full scale span 20 V or 10 V
        span_uv = wide_range ? 26'sd20000000 : 26'sd10000000;
        // Step is span over code count; round to nearest
        scaled = 48'(sample_uv) * 48'(`SACC_CODE_STEPS)
                 + 48'(span_uv >>> 1);
        q = scaled / 48'(span_uv);
        if (scaled < 0 && (scaled % 48'(span_uv)) != 0)
            q = q - 48'sd1;
        // Saturate to signed range
        if (q > 48'sd8191)
            code = 14'sh1fff;
        else if (q < -48'sd8192)
            code = 14'sh2000;
        else
            code = sacc_code_t'(q[13:0]);
    end
endmodule : sacc_coder

// ==== rtl/sacc_device.sv ====
// Converter end: sampling, timed conversion, busy, results.
// Assumes host drives pins synchronous to clk_sys.
`timescale 1ns/10ps
`include "sacc_cfg.svh"
module sacc_device
    import sacc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Link
    sacc_link_if.dev         link,
    // Analog samples, microvolts per channel
    input  wire logic [25*`SACC_NCHAN-1:0] analog_channel_inputs,
    // Status
    output logic             hold_first,
    output logic             hold_second,
    output logic             int_ref_on
);
    typedef struct packed {
        sacc_dev_e                       st;
        logic [7:0]                      cnt;
        logic                            a_d;
        logic                            b_d;
        logic                            ha;
        logic                            hb;
        logic                            busy;
        logic                            wide;
        logic                            iref;
        logic [25*`SACC_NCHAN-1:0]       smp;
        logic [`SACC_DW*`SACC_NCHAN-1:0] res;
    } sacc_dev_s;
    sacc_dev_s r, next_r;
    logic [`SACC_DW*`SACC_NCHAN-1:0] codes;
    logic rise_a;
    logic rise_b;
    genvar g;
    generate
        for (g = 0; g < `SACC_NCHAN; g++) begin : g_ch
            sacc_coder u_coder (
                .sample_uv  (r.smp[25*g +: 25]),
                .wide_range (r.wide),
                .code       (codes[`SACC_DW*g +: `SACC_DW])
            );
        end
    endgenerate
    assign rise_a = link.start_strobe_first_group & ~r.a_d;
    assign rise_b = link.start_strobe_second_group & ~r.b_d;
    always_comb begin
        next_r      = r;
        next_r.a_d  = link.start_strobe_first_group;
        next_r.b_d  = link.start_strobe_second_group;
        next_r.wide = link.range_sel;
        if (link.dev_reset) begin
            // Reset latches reference mode; range follows range_sel every cycle
            next_r.st       = SACC_D_IDLE;
            next_r.busy     = 1'b0;
            next_r.ha       = 1'b0;
            next_r.hb       = 1'b0;
            next_r.iref     = link.ref_sel;
        end else begin
            // Hold per group on a rising strobe unless already held
            if (rise_a && !r.ha) begin
                next_r.ha = 1'b1;
                for (int i = 0; i < 4; i++)
                    next_r.smp[25*i +: 25] = analog_channel_inputs[25*i +: 25];
            end
            if (rise_b && !r.hb) begin
                next_r.hb = 1'b1;
                for (int i = 4; i < 8; i++)
                    next_r.smp[25*i +: 25] = analog_channel_inputs[25*i +: 25];
            end
            case (r.st)
                SACC_D_IDLE, SACC_D_WAIT: begin
                    // Busy rises at the later strobe edge
                    if (next_r.ha && next_r.hb) begin
                        next_r.st   = SACC_D_CONV;
                        next_r.busy = 1'b1;
                        next_r.cnt  = 8'(`SACC_CONV_CYC - 1);
                    end else if (next_r.ha || next_r.hb) begin
                        next_r.st = SACC_D_WAIT;
                    end
                end
                SACC_D_CONV: begin
                    // Internal timing, done within 4 us
                    if (r.cnt == 8'h00) begin
                        // All eight coded, then busy falls
                        next_r.res  = codes;
                        next_r.busy = 1'b0;
                        next_r.ha   = 1'b0;
                        next_r.hb   = 1'b0;
                        next_r.st   = SACC_D_IDLE;
                    end else begin
                        next_r.cnt = r.cnt - 8'h01;
                    end
                end
                default: next_r.st = SACC_D_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    // Old results stay readable while busy
    assign link.busy   = r.busy;
    assign link.result = r.res;
    assign hold_first  = r.ha;
    assign hold_second = r.hb;
    assign int_ref_on  = r.iref;
endmodule : sacc_device

// ==== rtl/sacc_host.sv ====
// Controller end: Avalon slave registers driving conversion pins.
// Assumes the converter end on the same clk_sys.
//
// Contract
// - Range high wide span, low narrow
// - Wait 80 us after range change
// - Pulse reset after power-up
// - Start rising edge holds channel groups
// - Busy falls after all eight, track resumes
// - Internal conversion finishes within 4 us
// - New results valid once busy low
// - Results coded two's complement
// - Transitions at half LSB points
// - Step equals span over 16384
// - Reference select high internal, low external
// - After reset use selected reference mode
// - Busy high from start until finished
// - Split strobes start at later edge
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "sacc_cfg.svh"
module sacc_host
    import sacc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt
    output logic             irq,
    // Link
    sacc_link_if.host        link
);

    typedef struct packed {
        sacc_host_e  st;
        logic [15:0] cnt;
        logic [4:0]  ctrl;
        logic        act_range;
        logic        act_ref;
        logic        split;
        logic        sa;
        logic        sb;
        logic        rst_pin;
        logic        pend;
        logic [1:0]  ist;
        logic [1:0]  ien;
        logic        wreq;
        logic [31:0] rdata;
        logic        irq;
    } sacc_host_s;
    sacc_host_s r, next_r;
    logic       acc;
    logic [1:0] ev;

    // One wait state: the ack cycle blocks a second take of a held request
    assign acc = (avs_read | avs_write) & r.wreq;

    always_comb begin
        next_r      = r;
        ev          = 2'b00;
        next_r.wreq = ~acc;
        if (acc && avs_write) begin
            case (avs_address)
                `SACC_REG_CTRL: begin
                    next_r.ctrl = avs_writedata[4:0];
                    // Refuse starts while busy or unsettled
                    if (avs_writedata[`SACC_CTRL_START]) begin
                        if (r.st == SACC_H_READY && !link.busy)
                            next_r.pend = 1'b1;
                        else
                            ev[`SACC_IRQ_REFUSED] = 1'b1;
                    end
                end
                `SACC_REG_IRQ_CLR: next_r.ist = r.ist & ~avs_writedata[1:0];
                `SACC_REG_IRQ_EN:  next_r.ien = avs_writedata[1:0];
                default: ;
            endcase
        end

        // Start is a strobe and never reads back as set
        next_r.ctrl[`SACC_CTRL_START] = 1'b0;
        next_r.rdata = 32'h0;
        if (acc && avs_read) begin
            case (avs_address)
                `SACC_REG_CTRL:   next_r.rdata = {27'h0, r.ctrl};
                `SACC_REG_STATUS: next_r.rdata = {26'h0, r.st, r.act_ref,
                                                  r.act_range, link.busy};
                `SACC_REG_IRQ_STAT: next_r.rdata = {30'h0, r.ist};
                `SACC_REG_IRQ_EN: next_r.rdata = {30'h0, r.ien};
                default:          next_r.rdata = 32'h0;
            endcase
        end

        case (r.st)
            SACC_H_RESET: begin
                // Reset pulse to the converter, at power-up or on the reset bit
                next_r.rst_pin = 1'b1;
                next_r.act_range = r.ctrl[`SACC_CTRL_RANGE];
                next_r.act_ref   = r.ctrl[`SACC_CTRL_REFSEL];
                if (r.cnt == 16'h0) begin
                    next_r.rst_pin = 1'b0;
                    next_r.st      = SACC_H_SETTLE;
                    next_r.cnt     = 16'(`SACC_SETTLE_CYC);
                end else begin
                    next_r.cnt = r.cnt - 16'h1;
                end
            end
            SACC_H_SETTLE: begin
                // Settle after reset, settle plus acquisition after range change, acquisition after conversion
                if (r.cnt == 16'h0)
                    next_r.st = SACC_H_READY;
                else
                    next_r.cnt = r.cnt - 16'h1;
            end
            SACC_H_READY: begin
                if (r.ctrl[`SACC_CTRL_RESET]) begin
                    next_r.ctrl[`SACC_CTRL_RESET] = 1'b0;
                    next_r.st  = SACC_H_RESET;
                    next_r.cnt = 16'(`SACC_RESET_CYC);
                end else if (r.ctrl[`SACC_CTRL_RANGE] != r.act_range) begin
                    // Range moves only between conversions
                    next_r.act_range = r.ctrl[`SACC_CTRL_RANGE];
                    next_r.st  = SACC_H_SETTLE;
                    next_r.cnt = 16'(`SACC_SETTLE_CYC + `SACC_ACQ_CYC);
                end else if (r.pend) begin
                    next_r.pend  = 1'b0;
                    next_r.act_ref = r.ctrl[`SACC_CTRL_REFSEL];
                    next_r.split = r.ctrl[`SACC_CTRL_SPLIT];
                    // Both strobes together, or first then second
                    next_r.sa  = 1'b1;
                    next_r.sb  = ~r.ctrl[`SACC_CTRL_SPLIT];
                    next_r.st  = SACC_H_WAIT_BUSY;
                    next_r.cnt = 16'h4;
                end
            end
            SACC_H_WAIT_BUSY: begin
                if (r.split)
                    next_r.sb = 1'b1;
                if (link.busy) begin
                    next_r.sa = 1'b0;
                    next_r.sb = 1'b0;
                    next_r.st = SACC_H_WAIT_DONE;
                end else if (r.cnt == 16'h0) begin
                    // A start the converter never took is reported
                    // as refused rather than hanging here
                    ev[`SACC_IRQ_REFUSED] = 1'b1;
                    next_r.sa  = 1'b0;
                    next_r.sb  = 1'b0;
                    next_r.st  = SACC_H_SETTLE;
                    next_r.cnt = 16'(`SACC_ACQ_CYC);
                end else begin
                    next_r.cnt = r.cnt - 16'h1;
                end
            end
            SACC_H_WAIT_DONE: begin
                // Results taken only after busy falls
                if (!link.busy) begin
                    ev[`SACC_IRQ_DONE] = 1'b1;
                    next_r.st  = SACC_H_SETTLE;
                    next_r.cnt = 16'(`SACC_ACQ_CYC);
                end
            end
            default: next_r.st = SACC_H_RESET;
        endcase

        // Event set wins over a clear in the same cycle
        next_r.ist = next_r.ist | ev;
        next_r.irq = |(next_r.ist & next_r.ien);
    end

    // Waitrequest idles high so no request is taken during reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r.st        <= SACC_H_RESET;
            r.cnt       <= 16'(`SACC_RESET_CYC);
            r.ctrl      <= `SACC_CTRL_RST_VAL;
            r.act_range <= 1'b0;
            r.act_ref   <= 1'b0;
            r.split     <= 1'b0;
            r.sa        <= 1'b0;
            r.sb        <= 1'b0;
            r.rst_pin   <= 1'b0;
            r.pend      <= 1'b0;
            r.ist       <= 2'b00;
            r.ien       <= 2'b00;
            r.wreq      <= 1'b1;
            r.rdata     <= 32'h0;
            r.irq       <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign avs_readdata    = r.rdata;
    assign avs_waitrequest = r.wreq;
    assign irq             = r.irq;
    assign link.start_strobe_first_group  = r.sa;
    assign link.start_strobe_second_group = r.sb;
    assign link.range_sel = r.act_range;
    assign link.ref_sel   = r.act_ref;
    assign link.dev_reset = r.rst_pin;
endmodule : sacc_host

// ==== testbench/sacc_chk.sv ====
// Concurrent checks on the host to converter link pins.
// Assumes one clock; instantiated beside the link interface.
`timescale 1ns/10ps
`include "sacc_cfg.svh"
module sacc_chk (
    // Clock and reset
    input wire logic                            clk_sys,
    input wire logic                            rst_n,
    // Link pins
    input wire logic                            start_strobe_first_group,
    input wire logic                            start_strobe_second_group,
    input wire logic                            range_sel,
    input wire logic                            ref_sel,
    input wire logic                            dev_reset,
    input wire logic                            busy,
    input wire logic [`SACC_DW*`SACC_NCHAN-1:0] result
);
    localparam int CONV   = `SACC_CONV_CYC;
    localparam int SETTLE = `SACC_SETTLE_CYC;
    logic [7:0]  busy_len;
    logic [11:0] since_rng;
    wire         both = start_strobe_first_group && start_strobe_second_group;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Counts high cycles of busy; cleared whenever busy is low
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !busy)
            busy_len <= 8'h00;
        else
            busy_len <= busy_len + 8'h01;
    end
    // Saturates so a long idle never wraps into a false short settle
    always_ff @(posedge clk_sys) begin
        if (!rst_n || $changed(range_sel))
            since_rng <= 12'h000;
        else if (since_rng != 12'hfff)
            since_rng <= since_rng + 12'h001;
    end
    sequence s_start;
        both && !$past(both);
    endsequence
    sequence s_reset_pulse;
        dev_reset [*4] ##1 !dev_reset;
    endsequence
    AST_BUSY_RISE: assert property (
        s_start |-> ##[1:2] busy) else $error("busy missing after start");
    AST_BUSY_CAUSE: assert property (
        $rose(busy) |-> $past(both) || $past(both, 2))
        else $error("busy rose before both strobes");
    AST_CONV_TIME: assert property (
        disable iff (!rst_n || dev_reset) $fell(busy) |-> busy_len == CONV)
        else $error("conversion length wrong");
    AST_RESULT_AT_FALL: assert property (
        disable iff (!rst_n || dev_reset) $changed(result) |-> $fell(busy))
        else $error("result changed outside busy fall");
    AST_NO_START_BUSY: assert property (
        busy |-> !$rose(start_strobe_first_group)
                 && !$rose(start_strobe_second_group))
        else $error("start edge while busy");
    AST_LEVELS_HELD: assert property (
        busy |-> $stable(range_sel) && $stable(ref_sel))
        else $error("select level moved during conversion");
    AST_RESET_PULSE: assert property (
        $rose(dev_reset) |-> s_reset_pulse) else $error("reset pulse length");
    AST_QUIET_IN_RESET: assert property (
        dev_reset |-> !start_strobe_first_group && !start_strobe_second_group)
        else $error("start during device reset");
    AST_RANGE_SETTLE: assert property (
        $rose(start_strobe_first_group) |-> since_rng >= SETTLE)
        else $error("start too soon after range change");
endmodule : sacc_chk

// ==== testbench/testbench.sv ====
// Bench driving the host registers over Avalon, both ends joined.
// Assumes the host register map and 20 MHz clock of the hand-over.
`timescale 1ns/10ps
`include "sacc_cfg.svh"
module testbench
    import sacc_pkg::*;
    ;
    logic         clk_sys;
    logic         rst_n;
    logic [3:0]   avs_address;
    logic         avs_read;
    logic         avs_write;
    logic [31:0]  avs_writedata;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    logic         irq;
    logic [199:0] ain;
    logic         hold_first;
    logic         hold_second;
    logic         int_ref_on;
    logic [31:0]  q;
    int           n_errors;
    int           samples_checked;
    int           vals [8] = '{0, 1000, -1000, 5000000, -5000000, 9999000,
                               -10000000, 300};
    sacc_link_if link ();
    sacc_host i_sacc_host (.clk_sys, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
        .link(link.host));
    sacc_device i_sacc_device (.clk_sys, .rst_n, .link(link.dev),
        .analog_channel_inputs(ain), .hold_first, .hold_second, .int_ref_on);
    sacc_chk i_sacc_chk (.clk_sys, .rst_n,
        .start_strobe_first_group(link.start_strobe_first_group),
        .start_strobe_second_group(link.start_strobe_second_group),
        .range_sel(link.range_sel), .ref_sel(link.ref_sel),
        .dev_reset(link.dev_reset), .busy(link.busy), .result(link.result));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        chk({31'h0, avs_waitrequest}, 32'h0);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic wait_busy(input logic want);
        int n;
        n = 0;
        while (link.busy !== want && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        chk({31'h0, link.busy}, {31'h0, want});
    endtask : wait_busy
    // Settle after reset or range change lasts 1600 to 1620 cycles
    task automatic wait_ready;
        int n;
        n = 0;
        q = 32'h0;
        while (q[5:3] !== SACC_H_READY && n < 1000) begin
            bus(1'b0, `SACC_REG_STATUS, 32'h0);
            n++;
        end
    endtask : wait_ready
    function automatic logic [31:0] code(input int uv, input logic wide);
        real x;
        int  c;
        x = uv * 16384.0 / (wide ? 20.0e6 : 10.0e6) + 0.5;
        c = $rtoi($floor(x));
        if (c > 8191)
            c = 8191;
        if (c < -8192)
            c = -8192;
        return {{18{c[13]}}, c[13:0]};
    endfunction : code
    task automatic load(input logic inv);
        for (int i = 0; i < 8; i++)
            ain[25*i+:25] <= inv ? ~vals[i][24:0] : vals[i][24:0];
    endtask : load
    // Inputs are scrambled once busy is up: results must keep the held ones
    task automatic conv(input logic [31:0] ctl, input logic wide);
        bus(1'b1, `SACC_REG_CTRL, ctl);
        wait_busy(1'b1);
        chk({30'h0, hold_second, hold_first}, 32'h3);
        load(1'b1);
        wait_busy(1'b0);
        for (int i = 0; i < 8; i++)
            chk({{18{link.result[14*i+13]}}, link.result[14*i+:14]},
                code(vals[i], wide));
        repeat (25) @(posedge clk_sys);
        chk({30'h0, hold_second, hold_first}, 32'h0);
        load(1'b0);
    endtask : conv
    task automatic final_report;
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        final_report;
    end
    initial begin
        rst_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        n_errors = 0;
        samples_checked = 0;
        load(1'b0);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`SACC_REG_CTRL, 32'h4);
        rd(`SACC_REG_IRQ_STAT, 32'h0);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        rd(4'h2, 32'h0);
        wait_ready;
        rd(`SACC_REG_STATUS, {26'h0, SACC_H_READY, 3'h2});
        chk({31'h0, int_ref_on}, 32'h0);
        bus(1'b1, 4'h1, 32'h3);
        conv(32'h5, 1'b1);
        chk({31'h0, irq}, 32'h1);
        rd(`SACC_REG_IRQ_STAT, 32'h1);
        bus(1'b1, `SACC_REG_IRQ_CLR, 32'h1);
        rd(`SACC_REG_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `SACC_REG_CTRL, 32'h5);
        bus(1'b1, `SACC_REG_CTRL, 32'h5);
        wait_busy(1'b0);
        repeat (25) @(posedge clk_sys);
        rd(`SACC_REG_IRQ_STAT, 32'h3);
        bus(1'b1, `SACC_REG_IRQ_CLR, 32'h3);
        bus(1'b1, `SACC_REG_CTRL, 32'h0);
        wait_ready;
        chk({31'h0, link.range_sel}, 32'h0);
        conv(32'h3, 1'b0);
        bus(1'b1, `SACC_REG_CTRL, 32'h18);
        wait_ready;
        chk({30'h0, int_ref_on, link.ref_sel}, 32'h3);
        bus(1'b1, 4'h1, 32'h0);
        bus(1'b1, `SACC_REG_IRQ_CLR, 32'h3);
        conv(32'h9, 1'b0);
        chk({31'h0, irq}, 32'h0);
        rd(`SACC_REG_IRQ_STAT, 32'h1);
        final_report;
    end
endmodule : testbench
